// file: core/lcd_ctrl_regs.vh
// Purpose: Register offsets, fields and reset values of the LCD pin and display control
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Guarded against double inclusion
`ifndef LCD_CTRL_REGS_VH
`define LCD_CTRL_REGS_VH
// ==========================================
// Offsets
`define PIN_CTRL_ADDR 2'h0
`define LCD_CTRL_ADDR 2'h1
`define STAT_ADDR 2'h2
// ==========================================
// Pin control fields
`define SEL_LSB 0
`define SEL_MSB 3
`define COM_PARALLEL_BIT 5
`define DUTY_LO_BIT 6
`define DUTY_HI_BIT 7
`define PIN_CTRL_RESET 8'h00
`define PIN_CTRL_WMASK 8'hEF
// ==========================================
// Control fields
`define SRC_BIT 4
`define ACTIVATE_BIT 5
`define LADDER_BIT 6
`define RSVD_BIT 7
`define LCD_CTRL_RESET 8'h00
`define LCD_CTRL_WMASK 8'h7F
`define GROUP_COUNT 9
`endif

// file: core/lcd_pin_display_ctrl.v
// Purpose: Pin sharing, ladder switch, activate and blanking of a segment LCD driver
// Assumes: Waveform engine and port logic sit outside; standby is a level from outside this clock
// Notes: Read data stand one cycle after the read strobe
// Notes: Pin outputs and status follow a write by two edges
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "lcd_ctrl_regs.vh"
module lcd_pin_display_ctrl #(
   parameter SEG_PINS = 40
) (
   input wire clock,
   input wire rst_n,
   input wire [1:0] addr,
   input wire [7:0] wrData,
   input wire wrStrobe,
   input wire rdStrobe,
   output reg [7:0] rdData,
   input wire standby,
   input wire [SEG_PINS-1:0] segWaveIn,
   input wire [3:0] comWaveIn,
   input wire [SEG_PINS-1:0] segPortOut,
   input wire [SEG_PINS-1:0] segPortOe,
   input wire [3:0] comPortOut,
   input wire [3:0] comPortOe,
   output reg [SEG_PINS-1:0] segPinOut,
   output reg [SEG_PINS-1:0] segPinOe,
   output reg [SEG_PINS-1:0] segLcdEn,
   output reg [3:0] comPinOut,
   output reg [3:0] comPinOe,
   output reg [3:0] comLcdEn,
   output reg ladderOn,
   output reg driverRun,
   output reg blankData,
   output reg [1:0] dutySel,
   output reg expandAllowed
);
   // ==========================================
   // Registers
   reg [7:0] pinCtrl_q;
   reg [7:0] lcdCtrl_q;
   reg standbyMeta_q;
   reg standby_q;
   reg [SEG_PINS-1:0] segEn;
   reg [3:0] comEn;
   wire [`GROUP_COUNT-1:0] groupLcd;
   wire [3:0] selCode;
   wire [1:0] dutyCode;
   wire active;
   wire pinCtrlWrite;
   wire lcdCtrlWrite;
   // Next values of the registered outputs
   wire ladderOn_d;
   wire driverRun_d;
   wire [SEG_PINS-1:0] segPinOut_d;
   wire [SEG_PINS-1:0] segPinOe_d;
   wire [3:0] comPinOut_d;
   wire [3:0] comPinOe_d;
   genvar p;

   // ==========================================
   // Decodes
   assign selCode = pinCtrl_q[`SEL_MSB:`SEL_LSB];
   assign dutyCode = {pinCtrl_q[`DUTY_HI_BIT], pinCtrl_q[`DUTY_LO_BIT]};
   assign active = lcdCtrl_q[`ACTIVATE_BIT];
   assign pinCtrlWrite = wrStrobe && (addr == `PIN_CTRL_ADDR);
   assign lcdCtrlWrite = wrStrobe && (addr == `LCD_CTRL_ADDR);
   // Standby and halt both drop the ladder, whatever its own bit says
   assign ladderOn_d = lcdCtrl_q[`LADDER_BIT] & active & ~standby_q;
   assign driverRun_d = active & ~standby_q;

   function [SEG_PINS-1:0] expandGroups;
      input [`GROUP_COUNT-1:0] g;
      integer k;
      begin
         expandGroups = {SEG_PINS{1'b0}};
         for (k = 0; k < SEG_PINS; k = k + 1) begin
            if (k >= SEG_PINS - 8) begin
               expandGroups[k] = g[0];
            end else begin
               expandGroups[k] = g[`GROUP_COUNT - 1 - k / 4];
            end
         end
      end
   endfunction

   // Commons the duty setting uses; parallel mode drives all four in static and half duty, three in third duty
   function [3:0] comUsed;
      input [1:0] duty;
      input cmx;
      begin
         case (duty)
            2'h0: comUsed = cmx ? 4'hF : 4'h1;
            2'h1: comUsed = cmx ? 4'hF : 4'h3;
            2'h2: comUsed = cmx ? 4'h7 : 4'h7;
            default: comUsed = 4'hF;
         endcase
      end
   endfunction

   seg_group_decode #(
      .GROUPS(`GROUP_COUNT)
   ) decode (
      .sel(selCode),
      .groupLcd(groupLcd)
   );

   // ==========================================
   // Standby synchroniser
   // Standby is a chip level from outside this clock, two flops before use
   always @(posedge clock) begin
      if (!rst_n) begin
         standbyMeta_q <= 1'b0;
         standby_q <= 1'b0;
      end else begin
         standbyMeta_q <= standby;
         standby_q <= standbyMeta_q;
      end
   end

   // ==========================================
   // Register writes
   always @(posedge clock) begin
      if (!rst_n) begin
         pinCtrl_q <= `PIN_CTRL_RESET;
         lcdCtrl_q <= `LCD_CTRL_RESET;
      end else begin
         // Activate clear touches nothing else, so setup survives a halt
         if (pinCtrlWrite) begin
            pinCtrl_q <= wrData & `PIN_CTRL_WMASK;
         end
         if (lcdCtrlWrite) begin
            lcdCtrl_q <= wrData & `LCD_CTRL_WMASK;
         end
      end
   end

   // ==========================================
   // Register reads
   // Zero outside the read cycle, so a stale value never looks like data
   always @(posedge clock) begin
      if (!rst_n) begin
         rdData <= 8'h00;
      end else if (rdStrobe) begin
         case (addr)
            `PIN_CTRL_ADDR: rdData <= pinCtrl_q;
            `LCD_CTRL_ADDR: rdData <= lcdCtrl_q | (8'h01 << `RSVD_BIT);
            `STAT_ADDR: rdData <= {4'h0, expandAllowed, blankData, driverRun, ladderOn};
            default: rdData <= 8'h00;
         endcase
      end else begin
         rdData <= 8'h00;
      end
   end

   // ==========================================
   // Display state
   always @(posedge clock) begin
      if (!rst_n) begin
         ladderOn <= 1'b0;
         driverRun <= 1'b0;
         blankData <= 1'b1;
         dutySel <= 2'h0;
         expandAllowed <= 1'b1;
      end else begin
         ladderOn <= ladderOn_d;
         driverRun <= driverRun_d;
         // Blanking is reported only; the waveform engine applies it
         blankData <= ~lcdCtrl_q[`SRC_BIT];
         dutySel <= dutyCode;
         expandAllowed <= (selCode == 4'h0);
      end
   end

   // ==========================================
   // Pin ownership
   always @* begin
      segEn = expandGroups(groupLcd);
      // Zero select code gives the commons to the ports as well
      comEn = (selCode == 4'h0) ? 4'h0 : comUsed(dutyCode, pinCtrl_q[`COM_PARALLEL_BIT]);
   end

   // LCD pins are pulled from port logic entirely
   generate
      for (p = 0; p < SEG_PINS; p = p + 1) begin : segMux
         assign segPinOut_d[p] = segEn[p] ? segWaveIn[p] : segPortOut[p];
         assign segPinOe_d[p] = segEn[p] | segPortOe[p];
      end
      for (p = 0; p < 4; p = p + 1) begin : comMux
         assign comPinOut_d[p] = comEn[p] ? comWaveIn[p] : comPortOut[p];
         assign comPinOe_d[p] = comEn[p] | comPortOe[p];
      end
   endgenerate

   always @(posedge clock) begin
      if (!rst_n) begin
         segPinOut <= {SEG_PINS{1'b0}};
         segPinOe <= {SEG_PINS{1'b0}};
         segLcdEn <= {SEG_PINS{1'b0}};
         comPinOut <= 4'h0;
         comPinOe <= 4'h0;
         comLcdEn <= 4'h0;
      end else begin
         segPinOut <= segPinOut_d;
         segPinOe <= segPinOe_d;
         segLcdEn <= segEn;
         comPinOut <= comPinOut_d;
         comPinOe <= comPinOe_d;
         comLcdEn <= comEn;
      end
   end
endmodule

// file: core/seg_group_decode.v
// Purpose: Turns the segment-driver select code into per-group LCD enables
// Assumes: Group 0 is the top group of eight pins, groups 1..8 four pins each
// Notes: Pure combinational
`timescale 1ns/1ps
module seg_group_decode #(
   parameter GROUPS = 9
) (
   input wire [3:0] sel,
   output reg [GROUPS-1:0] groupLcd
);
   integer i;
   always @* begin
      groupLcd = {GROUPS{1'b0}};
      for (i = 0; i < GROUPS; i = i + 1) begin
         // Codes 1..7 add one group per step; 1xx0 stops above the bottom group
         if (sel[3]) begin
            groupLcd[i] = (i < GROUPS - 1) | sel[0];
         end else begin
            groupLcd[i] = (i < sel[2:0]);
         end
      end
   end
endmodule

// file: testbench/lcd_ctrl_checker.sv
// Purpose: Port checks of the LCD pin control
// Assumes: One clock, synchronous reset
// Notes: Bound to the top module
`timescale 1ns/1ps
module lcd_ctrl_checker #(parameter SEG_PINS = 40) (
   input wire clock,
   input wire rst_n,
   input wire [1:0] addr,
   input wire rdStrobe,
   input wire standby,
   input wire [7:0] rdData,
   input wire [SEG_PINS-1:0] segLcdEn,
   input wire [3:0] comLcdEn,
   input wire ladderOn,
   input wire driverRun,
   input wire expandAllowed
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ====
   // Properties
   property p_lad; ladderOn |-> driverRun; endproperty
   a_lad: assert property (p_lad) else $error("ladder while halted");
   property p_stb; standby [*4] |=> !driverRun && !ladderOn; endproperty
   a_stb: assert property (p_stb) else $error("runs in standby");
   property p_exp; expandAllowed == (segLcdEn == 0); endproperty
   a_exp: assert property (p_exp) else $error("expand mismatch");
   property p_com; expandAllowed |-> comLcdEn == 4'h0; endproperty
   a_com: assert property (p_com) else $error("commons not ports");
   property p_top; |segLcdEn |-> &segLcdEn[SEG_PINS-1 -: 8]; endproperty
   a_top: assert property (p_top) else $error("top group off");
   property p_idl; $past(rst_n) && !$past(rdStrobe) |-> rdData == 8'h00; endproperty
   a_idl: assert property (p_idl) else $error("stray read data");
   property p_rsv; rdStrobe && addr == 2'h1 |=> rdData[7]; endproperty
   a_rsv: assert property (p_rsv) else $error("bit 7 reads 0");
   property p_unm; rdStrobe && addr == 2'h3 |=> rdData == 8'h00; endproperty
   a_unm: assert property (p_unm) else $error("unmapped data");
   c_lad: cover property (ladderOn);
   c_all: cover property (&segLcdEn);
   c_stb: cover property (standby && driverRun);
endmodule
bind lcd_pin_display_ctrl lcd_ctrl_checker #(.SEG_PINS(SEG_PINS)) chk_i (.*);

// file: testbench/lcd_panel_model.sv
// Purpose: Glass seen from the segment pins
// Assumes: Only LCD-owned pins reach the panel
// Notes: Port pins stay dark
`timescale 1ns/1ps
module lcd_panel_model (
   input wire [39:0] segPinOut,
   input wire [39:0] segLcdEn,
   output wire [39:0] panelSeg
);
   // ====
   // Glass
   assign panelSeg = segPinOut & segLcdEn;
endmodule

// file: testbench/lcd_pin_display_ctrl_test.sv
// Purpose: Register and pin sharing regression
// Assumes: Outputs settle two edges after a write
// Notes: Directed only
`timescale 1ns/1ps
module lcd_pin_display_ctrl_test;
   logic clock = 0, rst_n = 0, wrStrobe = 0, rdStrobe = 0, standby = 0;
   logic [1:0] addr = 0, dutySel;
   logic [7:0] wrData = 0, rdData;
   logic [39:0] segWaveIn = 40'h0F0F0F0F0F, segPortOut = 40'hA55A3CC3F0, segPortOe = 40'hFF00FF00FF;
   logic [39:0] segPinOut, segPinOe, segLcdEn, m, panelSeg;
   logic [3:0] comWaveIn = 4'h5, comPortOut = 4'hA, comPortOe = 4'hF, comPinOut, comPinOe, comLcdEn;
   logic ladderOn, driverRun, blankData, expandAllowed;
   logic [3:0] ce;
   int n_fail = 0, n_compared = 0;
   lcd_pin_display_ctrl uut (.*);
   lcd_panel_model panel (.segPinOut(segPinOut), .segLcdEn(segLcdEn), .panelSeg(panelSeg));
   initial forever #12.5 clock = ~clock;
   // ====
   // Tasks
   task automatic chk(input logic [47:0] v, input logic [47:0] e);
      n_compared++;
      if (v !== e) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, v, e);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1;
      @(posedge clock);
      wrStrobe <= 0;
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge clock);
      addr <= a;
      rdStrobe <= 1;
      @(posedge clock);
      rdStrobe <= 0;
      #1;
   endtask
   task automatic end_of_test();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Bounded run: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      $display("wrong value at %0t: run did not finish", $time);
      end_of_test();
   end
   // ====
   // Sequence
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1;
      rd(2'h1);
      chk(rdData, 8'h80);
      for (int c = 0; c < 16; c++) begin
         m = c == 0 ? 0 : c < 8 ? ~40'h0 << (36 - 4 * c) : c[0] ? ~40'h0 : ~40'h0 << 4;
         ce = c == 0 ? 4'h0 : 4'hF >> (3 - c[1:0]);
         @(posedge clock) segPortOe <= ~segPortOe;
         wr(2'h0, {c[1:0], 2'h1, c[3:0]});
         chk(segLcdEn, m);
         chk(expandAllowed, c == 0);
         chk(segPinOut & ~m, segPortOut & ~m);
         chk(segPinOe & ~m, segPortOe & ~m);
         chk(segPinOut & m, segWaveIn & m);
         chk(segPinOe & m, m);
         chk(panelSeg, segWaveIn & m);
         chk(comLcdEn, ce);
         chk(comPinOut, (comWaveIn & ce) | (comPortOut & ~ce));
         chk(dutySel, c[1:0]);
         if (c == 0) chk({panelSeg, comLcdEn}, 0);
         rd(2'h0);
         chk(rdData, {c[1:0], 2'h0, c[3:0]});
      end
      wr(2'h1, 8'h70);
      chk({ladderOn, driverRun, blankData}, 3'h6);
      @(posedge clock) standby <= 1;
      repeat (5) @(posedge clock);
      #1 chk({ladderOn, driverRun}, 2'h0);
      @(posedge clock) standby <= 0;
      wr(2'h1, 8'h50);
      chk({ladderOn, driverRun, blankData}, 3'h0);
      rd(2'h1);
      chk(rdData, 8'hD0);
      rd(2'h0);
      chk(rdData, 8'hCF);
      wr(2'h1, 8'h20);
      chk({ladderOn, driverRun}, 2'h1);
      rd(2'h2);
      chk(rdData, 8'h06);
      rd(2'h3);
      chk(rdData, 8'h00);
      // Parallel commons in static, half and third duty
      wr(2'h0, 8'h21);
      chk(comLcdEn, 4'hF);
      wr(2'h0, 8'h61);
      chk(comLcdEn, 4'hF);
      wr(2'h0, 8'hA1);
      chk(comLcdEn, 4'h7);
      wr(2'h0, 8'h20);
      chk({comLcdEn, expandAllowed}, 5'h01);
      // Reset again in mid-run
      @(posedge clock) rst_n <= 0;
      repeat (2) @(posedge clock);
      rst_n <= 1;
      #1 chk({expandAllowed, blankData, ladderOn, driverRun, segLcdEn, comLcdEn}, {4'hC, 44'h0});
      rd(2'h0);
      chk(rdData, 8'h00);
      rd(2'h1);
      chk(rdData, 8'h80);
      end_of_test();
   end
endmodule
